// ===== design/flash_cfg_pkg.sv
// Package: opcodes, register field positions, reset values and timing for the register command block
package flash_cfg_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS_A = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS_B = 8'h31;
  localparam logic [7:0] OP_WRITE_CONFIG = 8'h11;
  localparam logic [7:0] OP_READ_EXT = 8'hC8;
  localparam logic [7:0] OP_WRITE_EXT = 8'h56;

  // ----------------------------------------------------------------
  // Configuration byte fields and reset value
  // ----------------------------------------------------------------
  localparam int CFG_PIN_ROLE = 7;
  localparam int CFG_DRV_HI = 6;
  localparam int CFG_DRV_LO = 5;
  localparam int CFG_PAGE_HI = 4;
  localparam int CFG_PAGE_LO = 3;
  localparam int CFG_PROT_SCHEME = 2;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFC;
  localparam logic [7:0] CFG_RESET = 8'h40;

  // ----------------------------------------------------------------
  // Extended (dummy and training) byte fields
  // ----------------------------------------------------------------
  localparam int EXT_DUMMY = 7;
  localparam int EXT_PATTERN = 3;
  localparam logic [7:0] EXT_WRITE_MASK = 8'h88;
  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] LEARN_PATTERN = 8'h34;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_STATUS_PROTECT_LOWER = 7;
  localparam int ST_STATUS_PROTECT_UPPER = 8;
  localparam int ST_QE = 9;
  localparam int ST_CMP = 14;
  localparam logic [15:0] ST_WRITE_MASK = 16'h7BFC;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Drive strength and page size codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DRV_100 = 2'h0;
  localparam logic [1:0] DRV_150 = 2'h1;
  localparam logic [1:0] DRV_200 = 2'h2;
  localparam logic [1:0] DRV_50 = 2'h3;
  localparam logic [1:0] PAGE_256 = 2'h0;
  localparam logic [1:0] PAGE_512 = 2'h1;
  localparam logic [1:0] PAGE_1024 = 2'h2;

  // ----------------------------------------------------------------
  // Dummy clock counts
  // ----------------------------------------------------------------
  localparam logic [3:0] DUAL_DUMMY_SHORT = 4'h4;
  localparam logic [3:0] DUAL_DUMMY_LONG = 4'h8;
  localparam logic [3:0] QUAD_DUMMY_SHORT = 4'h6;
  localparam logic [3:0] QUAD_DUMMY_LONG = 4'hA;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int REG_WRITE_TIME_US = 8;
  localparam int REG_WRITE_CYCLES = (REG_WRITE_TIME_US * 1000000) / CLK_PERIOD_PS;

  // Command decode states
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_SEND,
    ST_TAKE,
    ST_IGNORE
  } phase_type;

endpackage

// ===== design/link_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/1ps
`default_nettype none

module link_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= INIT;
      level_out <= INIT;
    end else begin
      meta_q <= pin_in;
      level_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ===== design/flash_config_register_commands.sv
// Serial flash register command block: configuration, status and extended register commands
// Functional notes
// - Configuration read works even while busy
// - Config byte out on SO; upper I/Os ignored
// - Config bit 7: hold or reset pin
// - Quad enable turns shared pin into data
// - Bits 6:5 select read drive strength
// - Bits 4:3 select page size, 11 reserved
// - Page size sets program buffer wrap point
// - Page erase covers double or quadruple page
// - Bit 2 selects protection scheme, locks set
// - Write-status needs write enable latch set
// - Status bits 15,10,1,0 never written
// - Write-status only at 8 or 16 bits
// - Eight-bit write clears complement, quad, protect
// - Timed write cycle; busy flag; latch clears
// - Hardware protected mode refuses write-status
// - Write-config: latch, one byte, exact boundary
// - Extended byte out on falling edges, MSB first
// - Extended bit 7 selects dummy clock counts
// - Learning pattern on all lines when enabled
// - Write-extended accepted only with latch set
// - Extended register clears on any reset
// - No register write while latch clear
`timescale 1ns/1ps
`default_nettype none

module flash_config_register_commands #(
  parameter int WRITE_CYCLES = flash_cfg_pkg::REG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic wp_n,
  // Configuration outputs to the rest of the device
  output logic hold_enable,
  output logic reset_pin_enable,
  output logic [1:0] drive_strength,
  output logic [1:0] page_size_select,
  output logic [9:0] page_wrap_mask,
  output logic [1:0] erase_page_span,
  output logic protect_scheme_select,
  output logic block_locks_all_set,
  output logic [3:0] dual_dummy_clocks,
  output logic [3:0] quad_dummy_clocks,
  output logic learning_pattern_enable,
  output logic [7:0] learning_pattern,
  output logic quad_enable,
  output logic protect_complement,
  output logic [4:0] block_protect_bits,
  output logic write_enable_latch,
  output logic write_in_progress
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic wp_s;
  logic cs_s;
  logic sclk_s;
  logic si_s;

  link_sync #(.WIDTH(4), .INIT(4'h9)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in({wp_n, cs_n, sclk, si}),
    .level_out(pins_s)
  );

  assign wp_s = pins_s[3];
  assign cs_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s = pins_s[0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic sclk_q, cs_q;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] ext_q, ext_d;
  logic [15:0] stat_q, stat_d;
  logic wel_q, wel_d;
  logic busy_q, busy_d;
  logic [31:0] wcnt_q, wcnt_d;
  logic [7:0] op_q, op_d;
  logic [7:0] sh_q, sh_d;
  logic [15:0] data_q, data_d;
  logic [4:0] bits_q, bits_d;
  logic [7:0] out_q, out_d;
  logic so_q, so_d;
  logic oe_q, oe_d;
  flash_cfg_pkg::phase_type ph_q, ph_d;
  logic [7:0] pend_cfg_q, pend_cfg_d;
  logic [15:0] pend_st_q, pend_st_d;
  logic [1:0] pend_kind_q, pend_kind_d;

  // ----------------------------------------------------------------
  // Edge and frame decode
  // ----------------------------------------------------------------
  wire rise = sclk_s & ~sclk_q;
  wire fall = ~sclk_s & sclk_q;
  wire frame_start = cs_q & ~cs_s;
  wire frame_end = ~cs_q & cs_s;
  wire active = ~cs_s;
  wire [7:0] op_next = {sh_q[6:0], si_s};
  wire [15:0] data_next = {data_q[14:0], si_s};

  // Hardware protect: lower protect with WP low, or the upper protect bit alone
  wire hw_protect = stat_q[flash_cfg_pkg::ST_STATUS_PROTECT_UPPER] |
                    (stat_q[flash_cfg_pkg::ST_STATUS_PROTECT_LOWER] & ~wp_s);

  wire is_write_status_cmd = (op_q == flash_cfg_pkg::OP_WRITE_STATUS_A) |
                 (op_q == flash_cfg_pkg::OP_WRITE_STATUS_B);
  wire is_write_config_cmd = op_q == flash_cfg_pkg::OP_WRITE_CONFIG;
  wire is_wrext = op_q == flash_cfg_pkg::OP_WRITE_EXT;

  // Status, config and extended write acceptance at frame end
  wire write_status_cmd_ok8 = is_write_status_cmd & (bits_q == 5'd8);
  wire write_status_cmd_ok16 = is_write_status_cmd & (bits_q == 5'd16);
  wire write_status_cmd_go = (write_status_cmd_ok8 | write_status_cmd_ok16) & wel_q & ~hw_protect & ~busy_q;
  wire write_config_cmd_go = is_write_config_cmd & (bits_q == 5'd8) & wel_q & ~busy_q;
  wire wrext_go = is_wrext & (bits_q == 5'd8) & wel_q & ~busy_q;

  // Status image after a write; protected bits keep their value
  function automatic logic [15:0] merge_status(input logic [15:0] old, input logic [15:0] nw);
    merge_status = (old & ~flash_cfg_pkg::ST_WRITE_MASK) | (nw & flash_cfg_pkg::ST_WRITE_MASK);
  endfunction

  // Eight-bit write: low byte given, upper protect/quad/complement cleared
  wire [15:0] st8 = {stat_q[15], 1'b0, stat_q[13:10], 1'b0, 1'b0, data_q[7:0]};
  wire [15:0] st_new = write_status_cmd_ok8 ? merge_status(stat_q, st8) : merge_status(stat_q, {data_q[7:0], data_q[15:8]});

  // Read-out byte for a read command, chosen at the opcode boundary
  wire [7:0] rd_byte = (op_next == flash_cfg_pkg::OP_READ_CONFIG) ? cfg_q :
                       (op_next == flash_cfg_pkg::OP_READ_EXT) ? ext_q :
                       (op_next == flash_cfg_pkg::OP_READ_STATUS_LO) ?
                         {stat_q[7:2], wel_q, busy_q} :
                       stat_q[15:8];
  wire op_is_read = (op_next == flash_cfg_pkg::OP_READ_CONFIG) |
                    (op_next == flash_cfg_pkg::OP_READ_EXT) |
                    (op_next == flash_cfg_pkg::OP_READ_STATUS_LO) |
                    (op_next == flash_cfg_pkg::OP_READ_STATUS_HI);
  wire op_is_write = (op_next == flash_cfg_pkg::OP_WRITE_STATUS_A) |
                     (op_next == flash_cfg_pkg::OP_WRITE_STATUS_B) |
                     (op_next == flash_cfg_pkg::OP_WRITE_CONFIG) |
                     (op_next == flash_cfg_pkg::OP_WRITE_EXT);

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  // All serial work keys off synchronised edges so sclk needs no clock domain
  always_comb begin
    ph_d = ph_q;
    op_d = op_q;
    sh_d = sh_q;
    data_d = data_q;
    bits_d = bits_q;
    out_d = out_q;
    so_d = so_q;
    oe_d = oe_q;
    if (frame_start) begin
      ph_d = flash_cfg_pkg::ST_OPCODE;
      bits_d = 5'd0;
      op_d = 8'h00;
    end else if (!active) begin
      oe_d = 1'b0;
      ph_d = flash_cfg_pkg::ST_IGNORE;
    end else if (rise) begin
      unique case (ph_q)
        flash_cfg_pkg::ST_OPCODE: begin
          sh_d = op_next;
          bits_d = bits_q + 5'd1;
          if (bits_q == 5'd7) begin
            op_d = op_next;
            bits_d = 5'd0;
            data_d = 16'h0000;
            out_d = rd_byte;
            ph_d = op_is_read ? flash_cfg_pkg::ST_SEND :
                   op_is_write ? flash_cfg_pkg::ST_TAKE : flash_cfg_pkg::ST_IGNORE;
          end
        end
        flash_cfg_pkg::ST_TAKE: begin
          data_d = data_next;
          // Saturate past 16 so an overlong frame is never accepted
          bits_d = (bits_q == 5'd17) ? bits_q : bits_q + 5'd1;
        end
        flash_cfg_pkg::ST_SEND: ;
        flash_cfg_pkg::ST_IGNORE: ;
      endcase
    end else if (fall && ph_q == flash_cfg_pkg::ST_SEND) begin
      so_d = out_q[7];
      out_d = {out_q[6:0], out_q[7]};
      oe_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register updates and timed write cycle
  // ----------------------------------------------------------------
  // Status and config writes land when the cycle ends; busy covers the timed interval
  always_comb begin
    cfg_d = cfg_q;
    ext_d = ext_q;
    stat_d = stat_q;
    wel_d = wel_q;
    busy_d = busy_q;
    wcnt_d = wcnt_q;
    pend_cfg_d = pend_cfg_q;
    pend_st_d = pend_st_q;
    pend_kind_d = pend_kind_q;
    if (busy_q) begin
      if (wcnt_q == 32'd1) begin
        busy_d = 1'b0;
        wel_d = 1'b0;
        if (pend_kind_q == 2'd1) begin
          stat_d = pend_st_q;
        end else begin
          cfg_d = pend_cfg_q;
        end
      end else begin
        wcnt_d = wcnt_q - 32'd1;
      end
    end else if (frame_end) begin
      if (ph_q == flash_cfg_pkg::ST_IGNORE && op_q == flash_cfg_pkg::OP_WRITE_ENABLE) begin
        wel_d = 1'b1;
      end else if (ph_q == flash_cfg_pkg::ST_IGNORE && op_q == flash_cfg_pkg::OP_WRITE_DISABLE) begin
        wel_d = 1'b0;
      end else if (write_status_cmd_go) begin
        pend_st_d = st_new;
        pend_kind_d = 2'd1;
        busy_d = 1'b1;
        wcnt_d = WRITE_CYCLES;
      end else if (write_config_cmd_go) begin
        pend_cfg_d = data_q[7:0] & flash_cfg_pkg::CFG_WRITE_MASK;
        pend_kind_d = 2'd2;
        busy_d = 1'b1;
        wcnt_d = WRITE_CYCLES;
      end else if (wrext_go) begin
        ext_d = data_q[7:0] & flash_cfg_pkg::EXT_WRITE_MASK;
        wel_d = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  // Extended byte returns to zero on every reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      cfg_q <= flash_cfg_pkg::CFG_RESET;
      ext_q <= flash_cfg_pkg::EXT_RESET;
      stat_q <= flash_cfg_pkg::ST_RESET;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      wcnt_q <= 32'd0;
      pend_cfg_q <= 8'h00;
      pend_st_q <= 16'h0000;
      pend_kind_q <= 2'd0;
    end else begin
      sclk_q <= sclk_s;
      cs_q <= cs_s;
      cfg_q <= cfg_d;
      ext_q <= ext_d;
      stat_q <= stat_d;
      wel_q <= wel_d;
      busy_q <= busy_d;
      wcnt_q <= wcnt_d;
      pend_cfg_q <= pend_cfg_d;
      pend_st_q <= pend_st_d;
      pend_kind_q <= pend_kind_d;
    end
  end

  // Serial shift state
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ph_q <= flash_cfg_pkg::ST_IGNORE;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      data_q <= 16'h0000;
      bits_q <= 5'd0;
      out_q <= 8'h00;
      so_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      op_q <= op_d;
      sh_q <= sh_d;
      data_q <= data_d;
      bits_q <= bits_d;
      out_q <= out_d;
      so_q <= so_d;
      oe_q <= oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode to the rest of the device
  // ----------------------------------------------------------------
  wire qe = stat_q[flash_cfg_pkg::ST_QE];
  wire [1:0] psel = cfg_q[flash_cfg_pkg::CFG_PAGE_HI:flash_cfg_pkg::CFG_PAGE_LO];
  wire dc = ext_q[flash_cfg_pkg::EXT_DUMMY];
  // Reserved page code falls back to 256-byte wrap as the safe choice
  wire [9:0] wrap_d = (psel == flash_cfg_pkg::PAGE_512) ? 10'h1FF :
                      (psel == flash_cfg_pkg::PAGE_1024) ? 10'h3FF : 10'h0FF;
  wire [1:0] span_d = (psel == flash_cfg_pkg::PAGE_512) ? 2'd1 :
                      (psel == flash_cfg_pkg::PAGE_1024) ? 2'd2 : 2'd0;

  // Registered outputs
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_enable <= 1'b0;
      reset_pin_enable <= 1'b0;
      drive_strength <= flash_cfg_pkg::DRV_200;
      page_size_select <= flash_cfg_pkg::PAGE_256;
      page_wrap_mask <= 10'h0FF;
      erase_page_span <= 2'd0;
      protect_scheme_select <= 1'b0;
      block_locks_all_set <= 1'b1;
      dual_dummy_clocks <= flash_cfg_pkg::DUAL_DUMMY_SHORT;
      quad_dummy_clocks <= flash_cfg_pkg::QUAD_DUMMY_SHORT;
      learning_pattern_enable <= 1'b0;
      learning_pattern <= 8'h00;
      quad_enable <= 1'b0;
      protect_complement <= 1'b0;
      block_protect_bits <= 5'h00;
      write_enable_latch <= 1'b0;
      write_in_progress <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      hold_enable <= ~qe & ~cfg_q[flash_cfg_pkg::CFG_PIN_ROLE];
      reset_pin_enable <= ~qe & cfg_q[flash_cfg_pkg::CFG_PIN_ROLE];
      drive_strength <= cfg_q[flash_cfg_pkg::CFG_DRV_HI:flash_cfg_pkg::CFG_DRV_LO];
      page_size_select <= psel;
      page_wrap_mask <= wrap_d;
      erase_page_span <= span_d;
      protect_scheme_select <= cfg_q[flash_cfg_pkg::CFG_PROT_SCHEME];
      block_locks_all_set <= 1'b1;
      dual_dummy_clocks <= dc ? flash_cfg_pkg::DUAL_DUMMY_LONG : flash_cfg_pkg::DUAL_DUMMY_SHORT;
      quad_dummy_clocks <= dc ? flash_cfg_pkg::QUAD_DUMMY_LONG : flash_cfg_pkg::QUAD_DUMMY_SHORT;
      learning_pattern_enable <= ext_q[flash_cfg_pkg::EXT_PATTERN];
      learning_pattern <= ext_q[flash_cfg_pkg::EXT_PATTERN] ? flash_cfg_pkg::LEARN_PATTERN : 8'h00;
      quad_enable <= qe;
      protect_complement <= stat_q[flash_cfg_pkg::ST_CMP];
      block_protect_bits <= stat_q[6:2];
      write_enable_latch <= wel_q;
      write_in_progress <= busy_q;
      so <= so_q;
      so_oe <= oe_q & active;
    end
  end

endmodule

`default_nettype wire

// ===== verification/flash_cfg_props.sv
// Checker: timing and field relations on the register command block ports
`timescale 1ns/1ps
`default_nettype none
module flash_cfg_props #(
  parameter int WRITE_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic wp_n,
  // Configuration outputs
  input wire logic hold_enable,
  input wire logic reset_pin_enable,
  input wire logic [1:0] drive_strength,
  input wire logic [1:0] page_size_select,
  input wire logic [9:0] page_wrap_mask,
  input wire logic [1:0] erase_page_span,
  input wire logic protect_scheme_select,
  input wire logic block_locks_all_set,
  input wire logic [3:0] dual_dummy_clocks,
  input wire logic [3:0] quad_dummy_clocks,
  input wire logic learning_pattern_enable,
  input wire logic [7:0] learning_pattern,
  input wire logic quad_enable,
  input wire logic protect_complement,
  input wire logic [4:0] block_protect_bits,
  input wire logic write_enable_latch,
  input wire logic write_in_progress
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ------------
  // Busy length counter
  // ------------
  int busy_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst || !write_in_progress) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end
  // Timed write cycle and latch handling
  a_busy_length: assert property ($fell(write_in_progress) |->
    busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1) else $error("busy length wrong");
  a_latch_clears: assert property ($fell(write_in_progress) |-> ##[0:1] !write_enable_latch)
    else $error("latch kept after write");
  a_start_needs_latch: assert property ($rose(write_in_progress) |-> write_enable_latch)
    else $error("write started without latch");
  a_cfg_frozen_busy: assert property (write_in_progress && $past(write_in_progress) |->
    $stable(drive_strength) && $stable(protect_scheme_select)) else $error("config moved mid cycle");
  a_cfg_needs_latch: assert property ($changed(drive_strength) || $changed(page_size_select) |->
    $past(write_enable_latch)) else $error("config written without latch");
  a_ext_needs_latch: assert property ($changed(learning_pattern_enable) |-> $past(write_enable_latch))
    else $error("extended written without latch");
  // Field decodes, idle output and reset state
  a_quad_frees_pin: assert property (quad_enable && $past(quad_enable) |-> !hold_enable && !reset_pin_enable)
    else $error("pin role active with quad");
  a_role_exclusive: assert property (!(hold_enable && reset_pin_enable)) else $error("both pin roles");
  a_dummy_pair: assert property ((dual_dummy_clocks == 4'h4 && quad_dummy_clocks == 4'h6) ||
    (dual_dummy_clocks == 4'h8 && quad_dummy_clocks == 4'ha)) else $error("dummy counts wrong");
  a_pattern_value: assert property ($stable(learning_pattern_enable) |->
    learning_pattern == (learning_pattern_enable ? 8'h34 : 8'h00)) else $error("pattern wrong");
  a_wrap_mask: assert property ($stable(page_size_select) |-> page_wrap_mask ==
    (page_size_select == 2'h1 ? 10'h1ff : page_size_select == 2'h2 ? 10'h3ff : 10'h0ff))
    else $error("wrap mask wrong");
  a_so_quiet: assert property (cs_n [*6] |=> !so_oe) else $error("output driven while idle");
  a_reset_state: assert property ($rose(nrst) |-> drive_strength == 2'h2 && dual_dummy_clocks == 4'h4 &&
    !learning_pattern_enable && !write_enable_latch) else $error("reset state wrong");
  // Main scenarios reached
  c_write_cycle: cover property ($fell(write_in_progress));
  c_pattern_on: cover property ($rose(learning_pattern_enable));
  c_quad_on: cover property ($rose(quad_enable));
endmodule
bind flash_config_register_commands flash_cfg_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_flash_cfg_props (.*);
`default_nettype wire

// ===== verification/spi_host_model.sv
// Host model: mode-0 frames on the link pins, link clock still between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output var logic cs_n,
  output var logic sclk,
  output var logic si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // n bits from top of b; rd gets last 8 so samples
  // Long low phase lets so settle before the rise
  task automatic frame(input logic [23:0] b, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      si = b[23 - i];
      repeat (5) @(posedge ref_clk);
      #1;
      rd = {rd[6:0], so};
      sclk = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      sclk = 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    #1;
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== verification/flash_config_register_commands_tb.sv
// Testbench: register commands driven through the host model
`timescale 1ns/1ps
`default_nettype none
module flash_config_register_commands_tb;
  localparam int WRITE_CYCLES = 300;
  logic ref_clk, nrst, cs_n, sclk, si, so, so_oe, wp_n, hold_enable, reset_pin_enable;
  logic protect_scheme_select, block_locks_all_set, learning_pattern_enable, quad_enable;
  logic protect_complement, write_enable_latch, write_in_progress;
  logic [1:0] drive_strength, page_size_select, erase_page_span;
  logic [9:0] page_wrap_mask;
  logic [3:0] dual_dummy_clocks, quad_dummy_clocks;
  logic [7:0] learning_pattern, rd, cur;
  logic [4:0] block_protect_bits;
  logic [7:0] cfg_vals [4] = '{8'h03, 8'ha8, 8'h54, 8'hfe};
  int err_count = 0;
  int samples_checked = 0;
  flash_config_register_commands #(.WRITE_CYCLES(WRITE_CYCLES)) u_flash_config_register_commands (.*);
  spi_host_model u_spi_host_model (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ------------
  // Shared helpers
  // ------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tx(input logic [7:0] op, input logic [15:0] d, input int n);
    u_spi_host_model.frame({op, d}, n, rd);
  endtask
  task automatic rdreg(input logic [7:0] op);
    tx(op, 16'h5a5a, 16);
  endtask
  task automatic write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_ENABLE, 16'h0000, 8);
  endtask
  // Bounded busy poll; timeout ends the run
  task automatic wait_idle();
    int k;
    k = 0;
    while (write_in_progress !== 1'b0) begin
      k++;
      if (k > 400) begin
        err_count++;
        finish_test();
      end
      @(posedge ref_clk);
      #1;
    end
  endtask
  // ------------
  // Scenarios
  // ------------
  task automatic t_reset();
    check(drive_strength, flash_cfg_pkg::DRV_200);
    check(page_wrap_mask, 10'h0ff);
    check({hold_enable, reset_pin_enable}, 2'b10);
    check({protect_scheme_select, block_locks_all_set}, 2'b01);
    check({write_enable_latch, write_in_progress, learning_pattern_enable, so_oe}, 4'h0);
    rdreg(flash_cfg_pkg::OP_READ_CONFIG);
    check(rd, flash_cfg_pkg::CFG_RESET);
    $display("t_reset done");
  endtask
  // All drive and page codes; busy reads show old byte
  task automatic t_cfg_writes();
    logic [7:0] v;
    logic [1:0] pg;
    for (int i = 0; i < 4; i++) begin
      v = cfg_vals[i];
      pg = v[4:3];
      write_enable_cmd();
      tx(flash_cfg_pkg::OP_WRITE_CONFIG, {v, 8'h00}, 16);
      check(write_in_progress, 1'b1);
      rdreg(flash_cfg_pkg::OP_READ_CONFIG);
      check(rd, cur);
      wait_idle();
      check(write_enable_latch, 1'b0);
      cur = v & 8'hfc;
      rdreg(flash_cfg_pkg::OP_READ_CONFIG);
      check(rd, cur);
      check(drive_strength, v[6:5]);
      check(page_size_select, pg);
      check(page_wrap_mask, pg == 2'h1 ? 10'h1ff : pg == 2'h2 ? 10'h3ff : 10'h0ff);
      if (pg != 2'h3) check(erase_page_span, pg);
      check({hold_enable, reset_pin_enable}, {~v[7], v[7]});
      check(protect_scheme_select, v[2]);
    end
    $display("t_cfg_writes done");
  endtask
  // Latchless and miscounted writes dropped
  task automatic t_refusals();
    tx(flash_cfg_pkg::OP_WRITE_CONFIG, 16'h0000, 16);
    check(write_in_progress, 1'b0);
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_CONFIG, 16'h0000, 15);
    check(write_in_progress, 1'b0);
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_STATUS_A, 16'h0000, 20);
    check(write_in_progress, 1'b0);
    tx(flash_cfg_pkg::OP_WRITE_DISABLE, 16'h0000, 8);
    check(write_enable_latch, 1'b0);
    rdreg(flash_cfg_pkg::OP_READ_CONFIG);
    check(rd, cur);
    $display("t_refusals done");
  endtask
  // 16- and 8-bit status writes, then hw protect
  task automatic t_status();
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_STATUS_B, 16'hd7c6, 24);
    wait_idle();
    check({quad_enable, protect_complement, block_protect_bits}, 7'h75);
    check({hold_enable, reset_pin_enable}, 2'b00);
    rdreg(flash_cfg_pkg::OP_READ_STATUS_LO);
    check(rd, 8'hd4);
    rdreg(flash_cfg_pkg::OP_READ_STATUS_HI);
    check(rd, 8'h42);
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_STATUS_A, 16'h8000, 16);
    wait_idle();
    check({quad_enable, protect_complement, block_protect_bits}, 7'h00);
    check({hold_enable, reset_pin_enable}, {~cur[7], cur[7]});
    rdreg(flash_cfg_pkg::OP_READ_STATUS_HI);
    check(rd, 8'h00);
    wp_n = 1'b0;
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_STATUS_A, 16'h7c00, 16);
    check(write_in_progress, 1'b0);
    check(block_protect_bits, 5'h00);
    wp_n = 1'b1;
    tx(flash_cfg_pkg::OP_WRITE_DISABLE, 16'h0000, 8);
    $display("t_status done");
  endtask
  // Extended byte: latch gating, readback, reset clearing
  task automatic t_ext();
    tx(flash_cfg_pkg::OP_WRITE_EXT, 16'hff00, 16);
    check(learning_pattern_enable, 1'b0);
    write_enable_cmd();
    tx(flash_cfg_pkg::OP_WRITE_EXT, 16'hff00, 16);
    check({learning_pattern_enable, learning_pattern}, 9'h134);
    check({dual_dummy_clocks, quad_dummy_clocks}, 8'h8a);
    check(write_enable_latch, 1'b0);
    rdreg(flash_cfg_pkg::OP_READ_EXT);
    check(rd, 8'h88);
    nrst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    check({learning_pattern_enable, dual_dummy_clocks, quad_dummy_clocks}, 9'h046);
    rdreg(flash_cfg_pkg::OP_READ_EXT);
    check(rd, 8'h00);
    $display("t_ext done");
  endtask
  initial begin
    nrst = 1'b0;
    wp_n = 1'b1;
    cur = flash_cfg_pkg::CFG_RESET;
    repeat (3) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    t_reset();
    t_cfg_writes();
    t_refusals();
    t_status();
    t_ext();
    finish_test();
  end
endmodule
`default_nettype wire
